// >>> src/mrf_core.sv
`timescale 1ns/1ps
module mrf_core #(
  parameter int unsigned SYSRAM_BYTES = mrf_pkg::SYSRAM_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic op_valid,
  input wire logic [3:0] op_kind,
  input wire logic [2:0] op_sel,
  input wire logic [7:0] op_addr,
  input wire logic [7:0] op_data,
  input wire logic [15:0] op_pc,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic br_valid,
  output logic br_taken,
  output logic [15:0] br_target,
  output logic [7:0] primary_operand_reg,
  output logic [7:0] second_operand_reg,
  output logic [7:0] alu_flag_word,
  output logic [7:0] stack_top_pointer,
  output logic [mrf_pkg::DATA_AW-1:0] xdata_addr,
  output logic xdata_in_sysram,
  output logic [mrf_pkg::CODE_AW-1:0] code_rd_addr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  logic [7:0] ram [mrf_pkg::RAM_DEPTH];
  logic [7:0] acc_ff, b_ff, psw_ff, sp_ff, peek_ff;
  logic dps_ff;
  logic [15:0] dptr0_ff, dptr1_ff;
  logic [15:0] tmr_ff [mrf_pkg::NUM_TMR];
  logic [2:0] trun_ff;
  logic rsp_valid_ff, br_valid_ff, br_taken_ff, xsys_ff;
  logic [7:0] rsp_data_ff;
  logic [15:0] br_target_ff, xaddr_ff, caddr_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic wstrb0_ff;
  logic fire, wr_ram, wr_sfr, nxt_taken;
  logic [1:0] bank;
  logic [7:0] wr_adr, wr_dat, rd_dat, bb, ind_adr, old;
  logic [7:0] nxt_acc, nxt_b, nxt_psw;
  logic [8:0] sum;
  logic [4:0] half;
  logic [15:0] prod, act_dptr;

  // ----------------------------------------
  // Address helpers
  // ----------------------------------------
  function automatic logic [7:0] reg_adr(input logic [1:0] bk, input logic [2:0] n);
    return {3'h0, bk, n}; // RULE14 RULE22
  endfunction : reg_adr

  function automatic logic [7:0] bit_byte(input logic [7:0] ba);
    if (ba[7]) begin
      return {ba[7:3], 3'h0}; // RULE19
    end
    return mrf_pkg::BIT_BASE + {4'h0, ba[6:3]}; // RULE17
  endfunction : bit_byte

  function automatic logic [7:0] sfr_rd(input logic [7:0] a);
    logic [7:0] v;
    v = mrf_pkg::SFR_UNIMPL;
    case (a)
      mrf_pkg::SFR_ACC: v = acc_ff;
      mrf_pkg::SFR_B: v = b_ff;
      mrf_pkg::SFR_PSW: v = psw_ff;
      mrf_pkg::SFR_SP: v = sp_ff;
      mrf_pkg::SFR_DPL0: v = dptr0_ff[7:0];
      mrf_pkg::SFR_DPH0: v = dptr0_ff[15:8];
      mrf_pkg::SFR_DPL1: v = dptr1_ff[7:0];
      mrf_pkg::SFR_DPH1: v = dptr1_ff[15:8];
      mrf_pkg::SFR_DPS: v = {7'h00, dps_ff};
      mrf_pkg::SFR_TRUN: v = {5'h00, trun_ff};
      mrf_pkg::TMR_LO[0]: v = tmr_ff[0][7:0];
      mrf_pkg::TMR_HI[0]: v = tmr_ff[0][15:8];
      mrf_pkg::TMR_LO[1]: v = tmr_ff[1][7:0];
      mrf_pkg::TMR_HI[1]: v = tmr_ff[1][15:8];
      mrf_pkg::TMR_LO[2]: v = tmr_ff[2][7:0];
      mrf_pkg::TMR_HI[2]: v = tmr_ff[2][15:8];
      default: v = mrf_pkg::SFR_UNIMPL;
    endcase
    return v;
  endfunction : sfr_rd

  // ----------------------------------------
  // Operand decode
  // ----------------------------------------
  assign fire = op_valid && ce;
  assign bank = psw_ff[mrf_pkg::PSW_RS1:mrf_pkg::PSW_RS0]; // RULE15
  assign act_dptr = dps_ff ? dptr1_ff : dptr0_ff; // RULE5 RULE21

  always_comb begin
    bb = bit_byte(op_addr);
    ind_adr = ram[reg_adr(bank, {2'h0, op_sel[0]})]; // RULE16
    old = op_addr[7] ? sfr_rd(bb) : ram[bb];
    wr_ram = 1'b0;
    wr_sfr = 1'b0;
    wr_adr = op_addr;
    wr_dat = op_data;
    rd_dat = 8'h00;
    if (fire) begin
      case (op_kind)
        mrf_pkg::OP_DIR_RD: rd_dat = op_addr[7] ? sfr_rd(op_addr) : ram[op_addr]; // RULE12
        mrf_pkg::OP_DIR_WR: begin
          wr_sfr = op_addr[7]; // RULE12 RULE13
          wr_ram = !op_addr[7];
        end
        mrf_pkg::OP_IND_RD: rd_dat = ram[ind_adr]; // RULE13
        mrf_pkg::OP_IND_WR: begin
          wr_ram = 1'b1; // RULE13
          wr_adr = ind_adr;
        end
        mrf_pkg::OP_REG_RD: rd_dat = ram[reg_adr(bank, op_sel)];
        mrf_pkg::OP_REG_WR: begin
          wr_ram = 1'b1;
          wr_adr = reg_adr(bank, op_sel);
        end
        mrf_pkg::OP_BIT_RD: rd_dat = {7'h00, old[op_addr[2:0]]}; // RULE18
        mrf_pkg::OP_BIT_WR: begin
          // Read-modify-write keeps the other seven bits untouched
          wr_sfr = op_addr[7]; // RULE18
          wr_ram = !op_addr[7];
          wr_adr = bb;
          wr_dat = old;
          wr_dat[op_addr[2:0]] = op_data[0];
        end
        mrf_pkg::OP_PUSH: begin
          wr_ram = 1'b1;
          wr_adr = sp_ff + 8'h01; // RULE7 RULE20
        end
        mrf_pkg::OP_POP: rd_dat = ram[sp_ff]; // RULE20
        default: rd_dat = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // ALU and flag word
  // ----------------------------------------
  always_comb begin
    sum = {1'b0, acc_ff} + {1'b0, op_data};
    half = {1'b0, acc_ff[3:0]} + {1'b0, op_data[3:0]};
    prod = acc_ff * b_ff;
    nxt_acc = (wr_sfr && wr_adr == mrf_pkg::SFR_ACC) ? wr_dat : acc_ff;
    nxt_b = (wr_sfr && wr_adr == mrf_pkg::SFR_B) ? wr_dat : b_ff;
    nxt_psw = (wr_sfr && wr_adr == mrf_pkg::SFR_PSW) ? wr_dat : psw_ff;
    if (fire && op_kind == mrf_pkg::OP_ALU) begin
      case (op_sel)
        mrf_pkg::FN_ADD: begin
          nxt_acc = sum[7:0]; // RULE1
          nxt_psw[mrf_pkg::PSW_CY] = sum[8]; // RULE3
          nxt_psw[mrf_pkg::PSW_AC] = half[4];
          nxt_psw[mrf_pkg::PSW_OV] = (acc_ff[7] == op_data[7]) && (sum[7] != acc_ff[7]);
        end
        mrf_pkg::FN_AND: nxt_acc = acc_ff & op_data; // RULE1
        mrf_pkg::FN_OR: nxt_acc = acc_ff | op_data;
        mrf_pkg::FN_XOR: nxt_acc = acc_ff ^ op_data;
        mrf_pkg::FN_MOV: nxt_acc = op_data;
        mrf_pkg::FN_MUL: begin
          nxt_acc = prod[7:0]; // RULE2
          nxt_b = prod[15:8];
          nxt_psw[mrf_pkg::PSW_CY] = 1'b0;
          nxt_psw[mrf_pkg::PSW_OV] = |prod[15:8];
        end
        mrf_pkg::FN_DIV: begin
          // Divide by zero flags overflow and leaves both operands as they were
          nxt_psw[mrf_pkg::PSW_CY] = 1'b0;
          nxt_psw[mrf_pkg::PSW_OV] = (b_ff == 8'h00);
          if (b_ff != 8'h00) begin
            nxt_acc = acc_ff / b_ff; // RULE2
            nxt_b = acc_ff % b_ff;
          end
        end
        default: nxt_acc = acc_ff;
      endcase
    end
    // Parity always tracks the accumulator, so a write to it is ignored
    nxt_psw[mrf_pkg::PSW_P] = ^nxt_acc; // RULE3
  end

  always_comb begin
    case (op_sel)
      mrf_pkg::BR_ZERO: nxt_taken = (acc_ff == 8'h00); // RULE4
      mrf_pkg::BR_NZERO: nxt_taken = (acc_ff != 8'h00);
      mrf_pkg::BR_CARRY: nxt_taken = psw_ff[mrf_pkg::PSW_CY];
      mrf_pkg::BR_NCARRY: nxt_taken = !psw_ff[mrf_pkg::PSW_CY];
      mrf_pkg::BR_ALWAYS: nxt_taken = 1'b1;
      default: nxt_taken = 1'b0;
    endcase
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (ce && wr_ram) begin
      ram[wr_adr] <= wr_dat; // RULE6
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= 8'h00;
      b_ff <= 8'h00;
      psw_ff <= 8'h00;
    end else if (ce) begin
      acc_ff <= nxt_acc;
      b_ff <= nxt_b;
      psw_ff <= nxt_psw;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_ff <= mrf_pkg::SP_RST; // RULE20
    end else if (wr_sfr && wr_adr == mrf_pkg::SFR_SP) begin
      sp_ff <= wr_dat;
    end else if (fire && op_kind == mrf_pkg::OP_PUSH) begin
      sp_ff <= sp_ff + 8'h01; // RULE20
    end else if (fire && op_kind == mrf_pkg::OP_POP) begin
      sp_ff <= sp_ff - 8'h01; // RULE20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dptr0_ff <= 16'h0000;
      dptr1_ff <= 16'h0000;
      dps_ff <= mrf_pkg::DPS_RST; // RULE21
    end else if (wr_sfr) begin
      case (wr_adr)
        mrf_pkg::SFR_DPL0: dptr0_ff[7:0] <= wr_dat; // RULE5
        mrf_pkg::SFR_DPH0: dptr0_ff[15:8] <= wr_dat;
        mrf_pkg::SFR_DPL1: dptr1_ff[7:0] <= wr_dat;
        mrf_pkg::SFR_DPH1: dptr1_ff[15:8] <= wr_dat;
        mrf_pkg::SFR_DPS: dps_ff <= wr_dat[0]; // RULE21
        default: dps_ff <= dps_ff;
      endcase
    end
  end

  // A byte write wins over the count in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trun_ff <= 3'h0;
      for (int i = 0; i < mrf_pkg::NUM_TMR; i++) begin
        tmr_ff[i] <= 16'h0000;
      end
    end else if (ce) begin
      if (wr_sfr && wr_adr == mrf_pkg::SFR_TRUN) begin
        trun_ff <= wr_dat[2:0]; // RULE8
      end
      for (int i = 0; i < mrf_pkg::NUM_TMR; i++) begin
        if (wr_sfr && wr_adr == mrf_pkg::TMR_LO[i]) begin
          tmr_ff[i][7:0] <= wr_dat; // RULE8
        end else if (wr_sfr && wr_adr == mrf_pkg::TMR_HI[i]) begin
          tmr_ff[i][15:8] <= wr_dat;
        end else if (trun_ff[i]) begin
          tmr_ff[i] <= tmr_ff[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
      br_valid_ff <= 1'b0;
      br_taken_ff <= 1'b0;
      br_target_ff <= 16'h0000;
    end else if (ce) begin
      rsp_valid_ff <= op_valid;
      rsp_data_ff <= rd_dat;
      br_valid_ff <= op_valid && op_kind == mrf_pkg::OP_BRANCH;
      br_taken_ff <= op_valid && op_kind == mrf_pkg::OP_BRANCH && nxt_taken;
      br_target_ff <= op_pc + {{8{op_data[7]}}, op_data}; // RULE4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xaddr_ff <= 16'h0000;
      caddr_ff <= 16'h0000;
      xsys_ff <= 1'b0;
    end else if (ce) begin
      xaddr_ff <= act_dptr; // RULE10
      xsys_ff <= {16'h0000, act_dptr} < SYSRAM_BYTES; // RULE11
      caddr_ff <= act_dptr + {8'h00, acc_ff}; // RULE9
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= mrf_pkg::RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
      peek_ff <= 8'h00;
    end else if (ce) begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        awaddr_ff <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (!awready_ff && !wready_ff && !bvalid_ff) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= mrf_pkg::RESP_SLVERR;
        if (awaddr_ff == mrf_pkg::AXI_PEEK_ADR) begin
          bresp_ff <= mrf_pkg::RESP_OKAY;
          if (wstrb0_ff) begin
            peek_ff <= wdata_ff[7:0];
          end
        end
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= mrf_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= mrf_pkg::RESP_OKAY;
        case ({s_axi_araddr[7:2], 2'h0})
          mrf_pkg::AXI_CORE: rdata_ff <= {sp_ff, psw_ff, b_ff, acc_ff};
          mrf_pkg::AXI_PTR: rdata_ff <= {15'h0000, dps_ff, act_dptr};
          mrf_pkg::AXI_PEEK_ADR: rdata_ff <= {24'h00_0000, peek_ff};
          mrf_pkg::AXI_PEEK_DAT: rdata_ff <= {24'h00_0000, ram[peek_ff]};
          default: begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= mrf_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign br_valid = br_valid_ff;
  assign br_taken = br_taken_ff;
  assign br_target = br_target_ff;
  assign primary_operand_reg = acc_ff;
  assign second_operand_reg = b_ff;
  assign alu_flag_word = psw_ff;
  assign stack_top_pointer = sp_ff;
  assign xdata_addr = xaddr_ff;
  assign xdata_in_sysram = xsys_ff;
  assign code_rd_addr = caddr_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_sp_reset;
    @(posedge aclk) $rose(aresetn) |-> sp_ff == 8'h07;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("sp not 07h after reset"); // RULE20
  property p_push;
    @(posedge aclk) disable iff (!aresetn)
      fire && op_kind == mrf_pkg::OP_PUSH |=> sp_ff == $past(sp_ff) + 8'h01
        && ram[sp_ff] == $past(op_data);
  endproperty
  a_push: assert property (p_push) else $error("push wrong"); // RULE7
  property p_pop;
    @(posedge aclk) disable iff (!aresetn)
      fire && op_kind == mrf_pkg::OP_POP |=> sp_ff == $past(sp_ff) - 8'h01
        && rsp_data == ram[$past(sp_ff)];
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong"); // RULE20
  property p_reg_adr;
    @(posedge aclk) disable iff (!aresetn)
      fire && op_kind == mrf_pkg::OP_REG_WR |-> wr_adr == {3'h0, bank, op_sel} && wr_ram;
  endproperty
  a_reg_adr: assert property (p_reg_adr) else $error("bank register address"); // RULE22
  property p_dir_sfr;
    @(posedge aclk) disable iff (!aresetn)
      fire && op_kind == mrf_pkg::OP_DIR_WR && op_addr[7] |-> wr_sfr && !wr_ram;
  endproperty
  a_dir_sfr: assert property (p_dir_sfr) else $error("direct high hit RAM"); // RULE12
  property p_bit_ram;
    @(posedge aclk) disable iff (!aresetn)
      fire && op_kind == mrf_pkg::OP_BIT_WR && !op_addr[7]
        |-> wr_adr == 8'h20 + {4'h0, op_addr[6:3]};
  endproperty
  a_bit_ram: assert property (p_bit_ram) else $error("bit byte address"); // RULE17
  property p_bit_sfr;
    @(posedge aclk) disable iff (!aresetn)
      fire && op_kind == mrf_pkg::OP_BIT_WR && op_addr[7] |-> wr_adr[2:0] == 3'h0;
  endproperty
  a_bit_sfr: assert property (p_bit_sfr) else $error("sfr bit not at 0 or 8"); // RULE19
  property p_mul;
    @(posedge aclk) disable iff (!aresetn)
      fire && op_kind == mrf_pkg::OP_ALU && op_sel == mrf_pkg::FN_MUL
        |=> {b_ff, acc_ff} == $past(acc_ff) * $past(b_ff);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply result"); // RULE2
  property p_parity;
    @(posedge aclk) disable iff (!aresetn) alu_flag_word[0] == ^primary_operand_reg;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag"); // RULE3
  property p_dptr;
    @(posedge aclk) disable iff (!aresetn) ce |=> xdata_addr == $past(act_dptr);
  endproperty
  a_dptr: assert property (p_dptr) else $error("data pointer select"); // RULE21
  property p_axi_r;
    @(posedge aclk) disable iff (!aresetn)
      ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_axi_r: assert property (p_axi_r) else $error("read answer late");
  c_push_pop: cover property (@(posedge aclk) fire && op_kind == mrf_pkg::OP_PUSH
    ##[1:8] fire && op_kind == mrf_pkg::OP_POP);
  c_bit_sfr: cover property (@(posedge aclk) fire && op_kind == mrf_pkg::OP_BIT_WR
    && op_addr[7]);
  c_div0: cover property (@(posedge aclk) fire && op_kind == mrf_pkg::OP_ALU
    && op_sel == mrf_pkg::FN_DIV && b_ff == 8'h00);
endmodule : mrf_core

// >>> src/mrf_pkg.sv
// Notes on behaviour
// RULE1: Accumulator is the main operand and result of ALU and transfer operations.
// RULE2: Second operand register feeds multiply and divide, otherwise a plain register.
// RULE3: Flag word holds carry, aux carry, overflow, parity, user flags, bank select.
// RULE4: ALU evaluates jump conditions and computes jump targets; no software access.
// RULE5: Two separate 16-bit data pointers address external data moves.
// RULE6: A 256-byte scratchpad RAM sits inside the core.
// RULE7: An 8-bit stack top pointer addresses the stack inside the scratchpad.
// RULE8: Three 16-bit timers, each two special register bytes, plus run control.
// RULE9: Code space is 64K bytes; code memory reads use the same space.
// RULE10: Data space is a separate 64K bytes reached by external data moves.
// RULE11: Data space includes internal system RAM of 8K to 64K bytes.
// RULE12: Direct accesses to 80h..FFh reach the special register space only.
// RULE13: Scratchpad 00h..7Fh direct or indirect; 80h..FFh indirect only.
// RULE14: Four banks of eight registers occupy scratchpad 00h..1Fh.
// RULE15: One bank active; two bank select bits in the flag word choose it.
// RULE16: Registers 0 and 1 of the active bank give indirect addresses.
// RULE17: Bytes 20h..2Fh are bit addressable; bit 00 is bit 0 of 20h.
// RULE18: The operation type alone decides bit or byte meaning of an address.
// RULE19: Only special registers at addresses ending 0 or 8 are bit addressable.
// RULE20: Stack pointer resets to 07h; increments before push, decrements after pop.
// RULE21: Bit 0 of pointer pair select picks the data pointer; resets to zero.
// RULE22: Register n of bank k lives at scratchpad address 8*k+n.
package mrf_pkg;
  localparam logic [3:0] OP_DIR_RD = 4'h1, OP_DIR_WR = 4'h2, OP_IND_RD = 4'h3;
  localparam logic [3:0] OP_IND_WR = 4'h4, OP_REG_RD = 4'h5, OP_REG_WR = 4'h6;
  localparam logic [3:0] OP_BIT_RD = 4'h7, OP_BIT_WR = 4'h8, OP_PUSH = 4'h9;
  localparam logic [3:0] OP_POP = 4'ha, OP_ALU = 4'hb, OP_BRANCH = 4'hc;
  localparam logic [2:0] FN_ADD = 3'h0, FN_AND = 3'h1, FN_OR = 3'h2, FN_XOR = 3'h3;
  localparam logic [2:0] FN_MUL = 3'h4, FN_DIV = 3'h5, FN_MOV = 3'h6;
  localparam logic [2:0] BR_ZERO = 3'h0, BR_NZERO = 3'h1, BR_CARRY = 3'h2;
  localparam logic [2:0] BR_NCARRY = 3'h3, BR_ALWAYS = 3'h4;
  localparam logic [7:0] SFR_ACC = 8'he0, SFR_B = 8'hf0, SFR_PSW = 8'hd0;
  localparam logic [7:0] SFR_SP = 8'h81, SFR_DPL0 = 8'h82, SFR_DPH0 = 8'h83;
  localparam logic [7:0] SFR_DPL1 = 8'h84, SFR_DPH1 = 8'h85, SFR_DPS = 8'h86;
  localparam logic [7:0] SFR_TRUN = 8'h88;
  localparam logic [7:0] TMR_LO [3] = '{8'h8a, 8'h8b, 8'hcc};
  localparam logic [7:0] TMR_HI [3] = '{8'h8c, 8'h8d, 8'hcd};
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic DPS_RST = 1'h0;
  localparam logic [7:0] SFR_UNIMPL = 8'hff;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam int PSW_CY = 7, PSW_AC = 6, PSW_RS1 = 4, PSW_RS0 = 3, PSW_OV = 2, PSW_P = 0;
  localparam int RAM_DEPTH = 256;
  localparam int NUM_TMR = 3;
  localparam int CODE_AW = 16;
  localparam int DATA_AW = 16;
  localparam int unsigned SYSRAM_DEF = 8192;
  localparam logic [7:0] AXI_CORE = 8'h00, AXI_PTR = 8'h04;
  localparam logic [7:0] AXI_PEEK_ADR = 8'h08, AXI_PEEK_DAT = 8'h0c;
  localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
endpackage : mrf_pkg

// >>> tb/mrf_dec_model.sv
`timescale 1ns/1ps
module mrf_dec_model (
  input wire logic aclk,
  output logic op_valid,
  output logic [3:0] op_kind,
  output logic [2:0] op_sel,
  output logic [7:0] op_addr,
  output logic [7:0] op_data,
  output logic [15:0] op_pc
);
  // ----------------------------------------
  // Decoder side of the op port
  // ----------------------------------------
  initial begin
    op_valid = 1'b0;
    op_kind = 4'h0;
    op_sel = 3'h0;
    op_addr = 8'h00;
    op_data = 8'h00;
    op_pc = 16'h0000;
  end
  // Back-to-back calls keep op_valid high, one op per cycle
  task automatic issue(input logic [3:0] k, input logic [2:0] s, input logic [7:0] a,
                       input logic [7:0] d, input logic [15:0] pc);
    @(posedge aclk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_sel <= s;
    op_addr <= a;
    op_data <= d;
    op_pc <= pc;
  endtask : issue
  // Idle kind, address and data fields are inverted so the core cannot lean on stale values
  task automatic idle();
    @(posedge aclk);
    op_valid <= 1'b0;
    op_kind <= ~op_kind;
    op_addr <= ~op_addr;
    op_data <= ~op_data;
  endtask : idle
endmodule : mrf_dec_model

// >>> tb/mcu_core_register_and_ram_map_tb.sv
`timescale 1ns/1ps
module mcu_core_register_and_ram_map_tb;
  logic aclk = 1'b0;
  logic aresetn, ce, op_valid, rsp_valid, br_valid, br_taken, xdata_in_sysram;
  logic [3:0] op_kind, s_axi_wstrb;
  logic [2:0] op_sel;
  logic [7:0] op_addr, op_data, rsp_data, primary_operand_reg, second_operand_reg, v;
  logic [7:0] alu_flag_word, stack_top_pointer, s_axi_awaddr, s_axi_araddr;
  logic [15:0] op_pc, br_target, xdata_addr, code_rd_addr, pc, p;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] expq [$];
  logic [16:0] brq [$];
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  integer seed = 32'h7d92;
  always #5 aclk = ~aclk;
  mrf_core #(.SYSRAM_BYTES(8192)) mrf_core_i (.aclk, .aresetn, .ce, .op_valid, .op_kind,
    .op_sel, .op_addr, .op_data, .op_pc, .rsp_valid, .rsp_data, .br_valid, .br_taken,
    .br_target, .primary_operand_reg, .second_operand_reg, .alu_flag_word,
    .stack_top_pointer, .xdata_addr, .xdata_in_sysram, .code_rd_addr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  mrf_dec_model mrf_dec_model_i (.aclk, .op_valid, .op_kind, .op_sel, .op_addr, .op_data,
    .op_pc);
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic op(input logic [3:0] k, input logic [2:0] s, input logic [7:0] a, d, e);
    expq.push_back(e);
    mrf_dec_model_i.issue(k, s, a, d, pc);
  endtask : op
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk({s_axi_rresp, s_axi_rdata}, {r, d});
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Results are matched in issue order; a pulse held by a low ce is taken once
  always @(posedge aclk) begin
    if (rsp_valid === 1'b1 && ce) chk(rsp_data, expq.pop_front());
    if (br_valid === 1'b1 && ce) chk({br_taken, br_target}, brq.pop_front());
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      test_done();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pc} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::SFR_SP, 8'h00, 8'h07);
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::SFR_DPS, 8'h00, 8'h00);
    v = 8'($random(seed));
    p = v * 16'h0012;
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_ACC, v, 8'h00);
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_B, 8'h12, 8'h00);
    op(mrf_pkg::OP_ALU, mrf_pkg::FN_MUL, 8'h00, 8'h00, 8'h00);
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::SFR_ACC, 8'h00, p[7:0]);
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::SFR_B, 8'h00, p[15:8]);
    for (int b = 0; b < 4; b++) begin
      op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_PSW, 8'(b * 8), 8'h00);
      for (int n = 0; n < 8; n++) begin
        v = 8'(b * 8 + n) ^ 8'ha5;
        op(mrf_pkg::OP_REG_WR, 3'(n), 8'h00, v, 8'h00);
        op(mrf_pkg::OP_DIR_RD, 3'h0, 8'(b * 8 + n), 8'h00, v);
      end
    end
    op(mrf_pkg::OP_REG_WR, 3'h0, 8'h00, 8'h90, 8'h00);
    op(mrf_pkg::OP_IND_WR, 3'h0, 8'h00, 8'h3c, 8'h00);
    op(mrf_pkg::OP_DIR_WR, 3'h0, 8'h90, 8'hc3, 8'h00);
    op(mrf_pkg::OP_IND_RD, 3'h0, 8'h00, 8'h00, 8'h3c);
    op(mrf_pkg::OP_DIR_RD, 3'h0, 8'h90, 8'h00, mrf_pkg::SFR_UNIMPL);
    op(mrf_pkg::OP_DIR_WR, 3'h0, 8'h21, 8'h00, 8'h00);
    op(mrf_pkg::OP_BIT_WR, 3'h0, 8'h0b, 8'h01, 8'h00);
    op(mrf_pkg::OP_DIR_RD, 3'h0, 8'h21, 8'h00, 8'h08);
    op(mrf_pkg::OP_BIT_RD, 3'h0, 8'he3, 8'h00, {7'h00, p[3]});
    op(mrf_pkg::OP_PUSH, 3'h0, 8'h00, 8'h77, 8'h00);
    op(mrf_pkg::OP_DIR_RD, 3'h0, 8'h08, 8'h00, 8'h77);
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::SFR_SP, 8'h00, 8'h08);
    op(mrf_pkg::OP_POP, 3'h0, 8'h00, 8'h00, 8'h77);
    pc = 16'($random(seed));
    v = 8'($random(seed));
    brq.push_back({1'b1, pc + {{8{v[7]}}, v}});
    op(mrf_pkg::OP_BRANCH, mrf_pkg::BR_ALWAYS, 8'h00, v, 8'h00);
    brq.push_back({1'b0, pc + 16'h0010});
    op(mrf_pkg::OP_BRANCH, mrf_pkg::BR_CARRY, 8'h00, 8'h10, 8'h00);
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_DPL0, 8'hff, 8'h00);
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_DPH0, 8'h1f, 8'h00);
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_DPL1, 8'h00, 8'h00);
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_DPH1, 8'h20, 8'h00);
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_DPS, 8'h01, 8'h00);
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::SFR_DPS, 8'h00, 8'h01);
    mrf_dec_model_i.idle();
    repeat (3) @(posedge aclk);
    chk(xdata_addr, 16'h2000);
    chk(xdata_in_sysram, 1'b0);
    chk(code_rd_addr, 16'h2000 + {8'h00, p[7:0]});
    chk(primary_operand_reg, p[7:0]);
    chk({stack_top_pointer, alu_flag_word, second_operand_reg}, {8'h07, 7'h0c, ^p[7:0], p[15:8]});
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_DPS, 8'h00, 8'h00);
    mrf_dec_model_i.idle();
    repeat (3) @(posedge aclk);
    chk(xdata_addr, 16'h1fff);
    chk(xdata_in_sysram, 1'b1);
    // Timer 0 runs; three frozen cycles must not add to its count
    op(mrf_pkg::OP_DIR_WR, 3'h0, mrf_pkg::SFR_TRUN, 8'h01, 8'h00);
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::TMR_LO[0], 8'h00, 8'h00);
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::TMR_LO[0], 8'h00, 8'h01);
    mrf_dec_model_i.idle();
    ce <= 1'b0;
    repeat (3) @(posedge aclk);
    ce <= 1'b1;
    op(mrf_pkg::OP_DIR_RD, 3'h0, mrf_pkg::TMR_LO[0], 8'h00, 8'h03);
    mrf_dec_model_i.idle();
    axi_rd(mrf_pkg::AXI_CORE, {8'h07, 7'h0c, ^p[7:0], p}, mrf_pkg::RESP_OKAY);
    axi_wr(mrf_pkg::AXI_PEEK_ADR, 32'h21, mrf_pkg::RESP_OKAY);
    axi_rd(mrf_pkg::AXI_PEEK_DAT, 32'h08, mrf_pkg::RESP_OKAY);
    axi_wr(mrf_pkg::AXI_CORE, 32'h0, mrf_pkg::RESP_SLVERR);
    axi_rd(8'h40, 32'h0, mrf_pkg::RESP_SLVERR);
    repeat (4) @(posedge aclk);
    chk(expq.size() + brq.size(), 0);
    test_done();
  end
endmodule : mcu_core_register_and_ram_map_tb
